//--- spc_defs.svh
// Purpose: Constants for the security page command block
// Assumes: 25 MHz core clock, serial link sampled by that clock
// Notes:   Opcodes, field positions, address codes and timing counts
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SPC_OP_WREN        8'h06
`define SPC_OP_STAT1       8'h05
`define SPC_OP_STAT2       8'h35
`define SPC_OP_ERASE       8'h44
`define SPC_OP_PROG        8'h42
`define SPC_OP_READ        8'h48

// ----------------------------------------------------------------
// Frame lengths in bytes, opcode included
// ----------------------------------------------------------------
`define SPC_LEN_OPCODE     4'h1
`define SPC_LEN_ADDR       4'h4
`define SPC_LEN_DUMMY      4'h5
`define SPC_LEN_MAX        4'hF

// ----------------------------------------------------------------
// Page decode and array values
// ----------------------------------------------------------------
`define SPC_PAGE_HI        8'h00
`define SPC_PAGE_FIRST     8'h01
`define SPC_PAGE_LAST      8'h03
`define SPC_ERASED_BYTE    8'hFF
`define SPC_WRAP_ADDR      10'h3FF
`define SPC_PAGE_NONE      2'h0

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define SPC_STAT1_BUSY     0
`define SPC_STAT1_WEL      1
`define SPC_STAT2_LOCK_LSB 3
`define SPC_PAGES          3

// ----------------------------------------------------------------
// Timing, times in microseconds, counts in core cycles
// ----------------------------------------------------------------
`define SPC_CLK_MHZ        25
`define SPC_ERASE_TIME_US  1000
`define SPC_PROG_TIME_US   500
`define SPC_ERASE_CYCLES   (`SPC_ERASE_TIME_US * `SPC_CLK_MHZ)
`define SPC_PROG_CYCLES    (`SPC_PROG_TIME_US * `SPC_CLK_MHZ)

`endif

//--- spc_pkg.sv
// Purpose: Types for the security page command block
// Assumes: Constants live in spc_defs.svh
// Notes:   States of the self-timed erase and program engine
package spc_pkg;

   // -------------------------------------------------------------
   // Engine states
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_IDLE,
      OP_WALK,
      OP_WAIT
   } spc_op_state_type;

endpackage

//--- spc_security_page_commands.sv
// Purpose: Security page erase, program and read over the serial link
// Assumes: Link pins are asynchronous and are sampled by core_clk;
//          the serial clock runs at most one eighth of core_clk
// Notes:   Page contents are undefined until a page is erased
//
// Overview of operation
// - Three separate pages, each erased, programmed, locked
// - Erase and program need write latch set
// - Erase 44h plus three address bytes
// - Erase is self-timed for block erase time
// - Erase ignores the low address byte
// - Erase frame must end after address byte
// - Busy flag reported while erase runs
// - Erase abort clears the write latch
// - Set lock bit stays set for good
// - Erase of a locked page is ignored
// - Page chosen by middle byte 01h-03h
// - Program reloads the internal 256-byte buffer
// - Program 42h plus three address bytes
// - Read 48h, address, then one dummy
// - Each later clock shifts out one bit
// - Read wraps from 3FFh to 000h seamlessly
// - Chip select release ends read, floats output
// - Low byte is byte address in page
// - Opcode 06h alone sets the write latch
// - Status one: busy bit 0, latch bit 1
// - Status two holds lock bits 5..3
`timescale 1ns/100ps

`include "spc_defs.svh"

module spc_security_page_commands #(
   parameter int unsigned ERASE_CYCLES = `SPC_ERASE_CYCLES,
   parameter int unsigned PROG_CYCLES  = `SPC_PROG_CYCLES
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // Serial link from the host
   input  wire logic       spiCsN,
   input  wire logic       spiSck,
   input  wire logic       spiMosi,
   output logic            spiMiso,
   output logic            spiMisoOeN,
   // One-time lock bits, pages three to one
   input  wire logic [2:0] pageLockBits,
   // Status
   output logic            busyFlag,
   output logic            writeLatch
);

   // -------------------------------------------------------------
   // Link synchronisers
   // -------------------------------------------------------------
   logic       csMeta_q, csSync_q, csPrev_q;
   logic       sckMeta_q, sckSync_q, sckPrev_q;
   logic       mosiMeta_q, mosiSync_q;

   // Two flops per pin, plus a third on select and clock for edge detect; the first stage feeds no logic
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {csMeta_q, csSync_q, csPrev_q}    <= 3'h7;
         {sckMeta_q, sckSync_q, sckPrev_q} <= 3'h0;
         {mosiMeta_q, mosiSync_q}          <= 2'h0;
      end else begin
         {csMeta_q, csSync_q, csPrev_q}    <= {spiCsN, csMeta_q, csSync_q};
         {sckMeta_q, sckSync_q, sckPrev_q} <= {spiSck, sckMeta_q, sckSync_q};
         {mosiMeta_q, mosiSync_q}          <= {spiMosi, mosiMeta_q};
      end
   end

   wire csActive = !csSync_q;
   wire csRise   = csSync_q & !csPrev_q;
   wire sckRise  = csActive & sckSync_q & !sckPrev_q;
   wire sckFall  = csActive & !sckSync_q & sckPrev_q;

   // -------------------------------------------------------------
   // Lock bits, sticky per page
   // -------------------------------------------------------------
   logic [2:0] lockQ;

   genvar gi;
   generate
      for (gi = 0; gi < `SPC_PAGES; gi++) begin : g_lock
         logic meta_q, sync_q, sticky_q;
         // Once seen set, only resetn clears it
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               {meta_q, sync_q, sticky_q} <= 3'h0;
            end else begin
               meta_q   <= pageLockBits[gi];
               sync_q   <= meta_q;
               sticky_q <= sticky_q | sync_q;
            end
         end
         assign lockQ[gi] = sticky_q;
      end
   endgenerate

   // -------------------------------------------------------------
   // Input shifter and frame counters
   // -------------------------------------------------------------
   logic [2:0] bitCnt_q;
   logic [3:0] byteCnt_q;
   logic [6:0] inShift_q;
   logic [7:0] opcode_q, addrHi_q, addrMid_q, addrLow_q;

   wire       byteDone = sckRise && (bitCnt_q == 3'h7);
   wire [7:0] inByte   = {inShift_q, mosiSync_q};
   wire       onByte   = (bitCnt_q == 3'h0);

   // Bits sampled on rising serial clock, mode 0 and 3
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bitCnt_q  <= 3'h0;
         byteCnt_q <= 4'h0;
         inShift_q <= 7'h00;
      end else if (!csActive) begin
         bitCnt_q  <= 3'h0;
         byteCnt_q <= 4'h0;
      end else if (sckRise) begin
         bitCnt_q  <= bitCnt_q + 3'h1;
         inShift_q <= inByte[6:0];
         if (bitCnt_q == 3'h7 && byteCnt_q != `SPC_LEN_MAX) begin
            byteCnt_q <= byteCnt_q + 4'h1;
         end
      end
   end

   // Opcode and address bytes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {opcode_q, addrHi_q, addrMid_q, addrLow_q} <= 32'h0000_0000;
      end else if (byteDone) begin
         case (byteCnt_q)
            4'h0:    opcode_q  <= inByte;
            4'h1:    addrHi_q  <= inByte;
            4'h2:    addrMid_q <= inByte;
            4'h3:    addrLow_q <= inByte;
            default: opcode_q  <= opcode_q;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Command decode at chip select release
   // -------------------------------------------------------------
   spc_pkg::spc_op_state_type opState_q;
   logic weLatch_q;

   wire busyInt   = (opState_q != spc_pkg::OP_IDLE);
   wire gotOp     = (byteCnt_q >= `SPC_LEN_OPCODE);
   wire validPage = (addrHi_q == `SPC_PAGE_HI) &&
                    (addrMid_q >= `SPC_PAGE_FIRST) &&
                    (addrMid_q <= `SPC_PAGE_LAST);
   wire [1:0] lockIdx    = addrMid_q[1:0] - 2'h1;
   wire       pageLocked = lockQ[lockIdx];
   wire       writeOk    = validPage && !pageLocked && onByte;
   wire isErase = gotOp && (opcode_q == `SPC_OP_ERASE);
   wire isProg  = gotOp && (opcode_q == `SPC_OP_PROG);
   wire wrCmd   = csRise && !busyInt && weLatch_q && (isErase || isProg);
   // Erase frame must stop right after the last address bit
   wire eraseOk = isErase && writeOk &&
                  (byteCnt_q == `SPC_LEN_ADDR);
   // Program needs at least one data byte
   wire progOk  = isProg && writeOk &&
                  (byteCnt_q > `SPC_LEN_ADDR);
   wire opStart = wrCmd && (eraseOk || progOk);
   wire wrAbort = wrCmd && !(eraseOk || progOk);
   wire cmdWren = csRise && !busyInt && onByte &&
                  (byteCnt_q == `SPC_LEN_OPCODE) &&
                  (opcode_q == `SPC_OP_WREN);

   // -------------------------------------------------------------
   // Program buffer
   // -------------------------------------------------------------
   logic [7:0]   bufData_q [0:255];
   logic [255:0] bufMask_q;
   logic [7:0]   progPtr_q;

   wire progByte = byteDone && !busyInt && isProg &&
                   (byteCnt_q >= `SPC_LEN_ADDR);
   wire progHead = byteDone && !busyInt && (byteCnt_q == 4'h0) &&
                   (inByte == `SPC_OP_PROG);

   // Buffer data is not reset; the mask says which bytes are live
   always_ff @(posedge core_clk) begin
      if (progByte) begin
         bufData_q[progPtr_q] <= inByte;
      end
   end

   // New program command wipes what an earlier one left behind
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bufMask_q <= 256'h0;
         progPtr_q <= 8'h00;
      end else if (progHead) begin
         bufMask_q <= 256'h0;
      end else if (byteDone && byteCnt_q == 4'h3) begin
         progPtr_q <= inByte;
      end else if (progByte) begin
         bufMask_q[progPtr_q] <= 1'b1;
         progPtr_q            <= progPtr_q + 8'h01; // wraps in page
      end
   end

   // -------------------------------------------------------------
   // Self-timed erase and program engine
   // -------------------------------------------------------------
   logic [7:0]  mem [1:3][0:255];
   logic        opErase_q;
   logic [1:0]  opPage_q;
   logic [7:0]  walkIdx_q;
   logic [31:0] timer_q;

   wire [31:0] waitLast = opErase_q ? 32'(ERASE_CYCLES - 1)
                                    : 32'(PROG_CYCLES - 1);
   wire        opDone   = (opState_q == spc_pkg::OP_WAIT) &&
                          (timer_q == waitLast);
   wire        walking  = (opState_q == spc_pkg::OP_WALK);
   wire [7:0]  oldByte  = mem[opPage_q][walkIdx_q];
   wire [7:0]  progVal  = bufMask_q[walkIdx_q] ?
                          (oldByte & bufData_q[walkIdx_q]) : oldByte;

   // Each page is its own row; low address ignored by erase
   always_ff @(posedge core_clk) begin
      if (walking) begin
         mem[opPage_q][walkIdx_q] <= opErase_q ? `SPC_ERASED_BYTE
                                               : progVal;
      end
   end

   // Walk the page once, then wait the whole erase or program time
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         opState_q <= spc_pkg::OP_IDLE;
         opErase_q <= 1'b0;
         opPage_q  <= `SPC_PAGE_NONE;
         walkIdx_q <= 8'h00;
         timer_q   <= 32'h0000_0000;
      end else begin
         case (opState_q)
            spc_pkg::OP_IDLE: begin
               if (opStart) begin
                  opState_q <= spc_pkg::OP_WALK;
                  opErase_q <= isErase;
                  opPage_q  <= addrMid_q[1:0];
                  walkIdx_q <= 8'h00;
               end
            end
            spc_pkg::OP_WALK: begin
               walkIdx_q <= walkIdx_q + 8'h01;
               timer_q   <= 32'h0000_0000;
               if (walkIdx_q == 8'hFF) begin
                  opState_q <= spc_pkg::OP_WAIT;
               end
            end
            spc_pkg::OP_WAIT: begin
               timer_q <= timer_q + 32'h0000_0001;
               if (opDone) begin
                  opState_q <= spc_pkg::OP_IDLE;
               end
            end
            default: opState_q <= spc_pkg::OP_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Write latch and status outputs
   // -------------------------------------------------------------
   // Latch clears in the same cycle that busy drops; commands other than status reads are ignored until idle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         weLatch_q  <= 1'b0;
         busyFlag   <= 1'b0;
         writeLatch <= 1'b0;
      end else begin
         if (opDone || wrAbort) begin
            weLatch_q <= 1'b0;
         end else if (cmdWren) begin
            weLatch_q <= 1'b1;
         end
         busyFlag   <= busyInt;
         writeLatch <= weLatch_q;
      end
   end

   wire [7:0] stat1 = {6'h00, weLatch_q, busyInt};
   wire [7:0] stat2 = {2'h0, lockQ, 3'h0};

   // -------------------------------------------------------------
   // Output shifter
   // -------------------------------------------------------------
   logic       outMode_q, outMem_q, outStat2_q;
   logic [2:0] outCnt_q;
   logic [6:0] outShift_q;
   logic [9:0] rdAddr_q;

   wire [7:0] rdByte  = (rdAddr_q[9:8] == `SPC_PAGE_NONE) ?
                        `SPC_ERASED_BYTE : mem[rdAddr_q[9:8]][rdAddr_q[7:0]];
   wire [7:0] nextOut = outMem_q ? rdByte : (outStat2_q ? stat2 : stat1);
   wire       loadOut = sckFall && outMode_q && (outCnt_q == 3'h0);
   wire       statCmd = byteDone && (byteCnt_q == 4'h0) &&
                        ((inByte == `SPC_OP_STAT1) ||
                         (inByte == `SPC_OP_STAT2));
   wire       readGo  = byteDone && !busyInt && isProg == 1'b0 &&
                        (opcode_q == `SPC_OP_READ) &&
                        (byteCnt_q == `SPC_LEN_DUMMY - 4'h1);

   // Output mode starts after the opcode or the dummy byte
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {outMode_q, outMem_q, outStat2_q} <= 3'h0;
         rdAddr_q <= 10'h000;
      end else if (!csActive) begin
         outMode_q <= 1'b0;
      end else if (statCmd) begin
         {outMode_q, outMem_q} <= 2'b10;
         outStat2_q <= (inByte == `SPC_OP_STAT2);
      end else if (readGo) begin
         {outMode_q, outMem_q} <= 2'b11;
         rdAddr_q <= {addrMid_q[1:0], addrLow_q};
      end else if (loadOut && outMem_q) begin
         rdAddr_q <= rdAddr_q + 10'h001;
      end
   end

   // Bits change on falling serial clock, msb first, repeating
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         outCnt_q   <= 3'h0;
         outShift_q <= 7'h00;
         spiMiso    <= 1'b0;
         spiMisoOeN <= 1'b1;
      end else if (!csActive) begin
         outCnt_q   <= 3'h0;
         spiMisoOeN <= 1'b1;
      end else if (sckFall && outMode_q) begin
         outCnt_q   <= outCnt_q + 3'h1;
         spiMisoOeN <= 1'b0;
         spiMiso    <= loadOut ? nextOut[7] : outShift_q[6];
         outShift_q <= loadOut ? nextOut[6:0] : {outShift_q[5:0], 1'b0};
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   AST_WREN_SETS_LATCH: assert property (
      cmdWren |-> ##1 weLatch_q ##1 writeLatch)
      else $error("write enable did not set latch");
   AST_OP_NEEDS_LATCH: assert property (
      $rose(busyInt) |-> $past(weLatch_q))
      else $error("operation started without write latch");
   AST_ERASE_FRAME: assert property (
      opStart && isErase |-> byteCnt_q == 4'h4 && bitCnt_q == 3'h0)
      else $error("erase started on a bad frame length");
   AST_ABORT_CLEARS: assert property (
      wrAbort |=> !weLatch_q && !busyInt)
      else $error("aborted write left latch or busy set");
   AST_LOCKED_IGNORED: assert property (
      opStart |-> !lockQ[addrMid_q[1:0] - 2'h1])
      else $error("operation started on a locked page");
   AST_PAGE_DECODE: assert property (
      $rose(busyInt) |-> opPage_q != 2'h0 && $past(addrHi_q) == 8'h00)
      else $error("operation on an undecoded page");
   AST_LOCK_STICKY: assert property (
      ##1 ((lockQ & $past(lockQ)) == $past(lockQ)))
      else $error("lock bit cleared");
   AST_BUSY_DURING_OP: assert property (
      opStart |=> ##1 busyFlag [*8])
      else $error("busy flag missing during operation");
   AST_LATCH_DROPS_AFTER_OP: assert property (
      $fell(busyInt) |-> !weLatch_q ##1 !writeLatch)
      else $error("write latch still set after operation");
   AST_MISO_RELEASE: assert property (
      csRise |=> spiMisoOeN && !outMode_q)
      else $error("output still driven after chip select release");
   AST_READ_WRAP: assert property (
      loadOut && outMem_q && rdAddr_q == 10'h3FF |=> rdAddr_q == 10'h000)
      else $error("read did not wrap to zero");

   COV_ERASE: cover property (opStart && isErase);
   COV_PROG: cover property (opStart && isProg);
   COV_WRAP: cover property (loadOut && outMem_q && rdAddr_q == 10'h3FF);
   COV_STATUS: cover property (statCmd ##[1:300] loadOut);

endmodule

//--- spc_host_model.sv
// Purpose: Host side of the serial link for the security page bench
// Assumes: Mode 0, msb first, 320 ns serial clock from a 40 ns core clock
// Notes:   Serial clock stands low outside frames; the data line shows
//          the inverse of its last bit while no frame is open
`timescale 1ns/100ps

module spc_host_model (
   // Clock
   input  wire logic core_clk,
   // Serial link
   output logic      spiCsN,
   output logic      spiSck,
   output logic      spiMosi,
   input  wire logic spiMiso,
   input  wire logic spiMisoOeN
);
   logic rxBits[$];
   logic oeSeen;

   // Idle link after time zero
   initial begin
      spiCsN  = 1'b1;
      spiSck  = 1'b0;
      spiMosi = 1'b0;
      oeSeen  = 1'b1;
   end

   // ----------------------------------------------------------------
   // One frame of nBits bits, bytes of tx msb first, zeros past its end
   // ----------------------------------------------------------------
   // Opcode, then address bytes, then dummy or data
   task automatic frame(input logic [7:0] tx[$], input int nBits);
      rxBits = {};
      @(negedge core_clk);
      spiCsN = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < nBits; i++) begin
         spiMosi = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : 1'b0;
         repeat (4) @(negedge core_clk);
         // Sample just before the rise; a released line reads inverted
         rxBits.push_back(spiMisoOeN ? ~spiMiso : spiMiso);
         oeSeen = spiMisoOeN;
         spiSck = 1'b1;
         repeat (4) @(negedge core_clk);
         spiSck = 1'b0;
      end
      // Release right after the last bit, cut frames stay cut
      repeat (2) @(negedge core_clk);
      spiCsN  = 1'b1;
      spiMosi = ~spiMosi;
      repeat (8) @(negedge core_clk);
   endtask
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench for the security page command block
// Assumes: Short erase and program times, driven at the falling edge
// Notes:   Model bytes of -1 are unknown and are not compared
`timescale 1ns/100ps

`include "spc_defs.svh"

module tb_top;
   logic       core_clk;
   logic       resetn;
   logic [2:0] pageLockBits;
   wire logic  spiCsN;
   wire logic  spiSck;
   wire logic  spiMosi;
   wire logic  spiMiso;
   wire logic  spiMisoOeN;
   wire logic  busyFlag;
   wire logic  writeLatch;
   int         num_errors;
   int         compares;
   integer     seed;
   int         mem[1024];
   logic       welM;
   logic [2:0] lockM;

   spc_security_page_commands #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) dut (
      .core_clk(core_clk), .resetn(resetn), .spiCsN(spiCsN),
      .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso),
      .spiMisoOeN(spiMisoOeN), .pageLockBits(pageLockBits),
      .busyFlag(busyFlag), .writeLatch(writeLatch));

   spc_host_model host (
      .core_clk(core_clk), .spiCsN(spiCsN), .spiSck(spiSck),
      .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOeN(spiMisoOeN));

   // 25 MHz core clock
   always #20 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // Compare, verdict and reply helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out;
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [7:0] rxByte(input int first);
      logic [7:0] v;
      for (int i = 0; i < 8; i++) v[7 - i] = host.rxBits[first + i];
      return v;
   endfunction

   // Status byte one shows latch and busy, byte two the locks
   task automatic status(output logic [7:0] s1);
      host.frame('{`SPC_OP_STAT2}, 16);
      chk("status2", {2'b00, lockM, 3'b000}, rxByte(8));
      host.frame('{`SPC_OP_STAT1}, 16);
      s1 = rxByte(8);
   endtask

   task automatic wren;
      host.frame('{`SPC_OP_WREN}, 8);
      welM = 1'b1;
      chk("writeLatch", welM, writeLatch);
   endtask

   // ----------------------------------------------------------------
   // Erase or program frame with the model's expectation
   // ----------------------------------------------------------------
   task automatic wr_op(input logic [7:0] tx[$], input int nBits);
      logic [7:0] pg;
      logic [7:0] s1;
      logic       ok;
      int         base;
      pg = tx[2];
      ok = welM && tx[1] == `SPC_PAGE_HI && pg inside {[1:3]} &&
           !lockM[pg[1:0] - 2'h1] && nBits % 8 == 0 &&
           (tx[0] == `SPC_OP_ERASE ? nBits == 32 : nBits >= 40);
      base = int'(pg) * 256;
      host.frame(tx, nBits);
      chk("busyFlag", ok, busyFlag);
      if (ok) begin
         status(s1);
         chk("status1 busy", 8'h03, s1);
         for (int i = 0; i < 20 && s1[0] !== 1'b0; i++) status(s1);
         for (int k = 0; k < 256; k++)
            if (tx[0] == `SPC_OP_ERASE) mem[base + k] = 255;
         for (int k = 4; k < nBits / 8; k++)
            if (mem[base + ((tx[3] + k - 4) & 255)] >= 0)
               mem[base + ((tx[3] + k - 4) & 255)] &= tx[k];
      end
      welM = 1'b0;
      chk("writeLatch", welM, writeLatch);
      status(s1);
      chk("status1 idle", 8'h00, s1);
   endtask

   // Read n bytes from a page address, optionally cut after extra bits
   task automatic rd(input logic [9:0] a, input int n, input int cut);
      host.frame('{`SPC_OP_READ, 8'h00, {6'h00, a[9:8]}, a[7:0]},
                 40 + 8 * n + cut);
      for (int k = 0; k < n; k++)
         if (mem[(a + k) % 1024] >= 0)
            chk("readByte", mem[(a+k)%1024], rxByte(40+8*k));
      chk("oeN during read", 1'b0, host.oeSeen);
      chk("oeN after read", 1'b1, spiMisoOeN);
   endtask

   // ----------------------------------------------------------------
   // Watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      #(80000 * 40);
      num_errors++;
      close_out;
   end

   initial begin
      core_clk = 1'b0;
      resetn = 1'b0;
      pageLockBits = 3'h0;
      seed = 39;
      welM = 1'b0;
      lockM = 3'h0;
      for (int i = 0; i < 1024; i++) mem[i] = (i < 256) ? 255 : -1;
      repeat (5) @(negedge core_clk);
      resetn = 1'b1;
      chk("reset busy", 1'b0, busyFlag);
      chk("reset oeN", 1'b1, spiMisoOeN);
      repeat (3) @(negedge core_clk);
      // Erase with the latch clear does nothing
      wr_op('{`SPC_OP_ERASE, 8'h00, 8'h01, 8'h00}, 32);
      // Each page erased on its own, low byte random
      for (int p = 1; p <= 3; p++) begin
         wren();
         wr_op('{`SPC_OP_ERASE, 8'h00, p[7:0], 8'($random(seed))},
               32);
      end
      // Program wraps inside the 256-byte buffer
      wren();
      wr_op('{`SPC_OP_PROG, 8'h00, 8'h01, 8'hFE, 8'($random(seed)),
              8'($random(seed)), 8'($random(seed)), 8'h5A},
            64);
      rd(10'h1FC, 8, 0);
      rd(10'h100, 2, 0);
      // Last byte then wrap to address zero without a gap
      wren();
      wr_op('{`SPC_OP_PROG, 8'h00, 8'h03, 8'hFF, 8'($random(seed))},
            40);
      rd(10'h3FE, 4, 0);
      // Aborts: short address, off boundary, bad page, no data, long
      wren();
      wr_op('{`SPC_OP_ERASE, 8'h00, 8'h02, 8'h00}, 24);
      wren();
      wr_op('{`SPC_OP_ERASE, 8'h00, 8'h02, 8'h00}, 36);
      wren();
      wr_op('{`SPC_OP_ERASE, 8'h01, 8'h02, 8'h00}, 32);
      wren();
      wr_op('{`SPC_OP_PROG, 8'h00, 8'h02, 8'h00}, 32);
      wren();
      wr_op('{`SPC_OP_ERASE, 8'h00, 8'h02, 8'h00, 8'h00}, 40);
      // Latch command cut short is ignored
      host.frame('{`SPC_OP_WREN}, 7);
      chk("writeLatch", 1'b0, writeLatch);
      // Lock page two, then drop the pin: lock must stick
      pageLockBits = 3'b010;
      repeat (6) @(negedge core_clk);
      pageLockBits = 3'b000;
      lockM = 3'b010;
      wren();
      wr_op('{`SPC_OP_ERASE, 8'h00, 8'h02, 8'h00}, 32);
      wren();
      wr_op('{`SPC_OP_PROG, 8'h00, 8'h02, 8'h00, 8'h00}, 40);
      rd({2'h2, 8'($random(seed))}, 4, 0);
      // Release mid-byte ends the read
      rd(10'h1FC, 1, 3);
      close_out();
   end
endmodule
